// File: inc/dcdbs_pkg.sv
// =====================================================================
// shared constants and types of the command decoder
package dcdbs_pkg;

  // =====================================================================
  // pin widths and field positions
  localparam int ADDR_W = 14;
  localparam int BA_W = 3;
  localparam int NBANK = 8;
  localparam int BST_W = 3;
  localparam int A10_BIT = 10;
  localparam int CNT_W = 8;

  // =====================================================================
  // timing, as printed, and derived cycle counts (least times round up)
  localparam int CLK_MHZ = 100;
  localparam int T_RCD_NS = 15;
  localparam int T_RP_NS = 15;
  localparam int T_RFC_NS = 195;
  localparam int T_XSNR_NS = 205;
  localparam int T_MRD_CK = 2;
  localparam logic [CNT_W-1:0] RCD_CYC = CNT_W'((T_RCD_NS * CLK_MHZ + 999) / 1000);
  localparam logic [CNT_W-1:0] RP_CYC = CNT_W'((T_RP_NS * CLK_MHZ + 999) / 1000);
  localparam logic [CNT_W-1:0] RFC_CYC = CNT_W'((T_RFC_NS * CLK_MHZ + 999) / 1000);
  localparam logic [CNT_W-1:0] XSNR_CYC = CNT_W'((T_XSNR_NS * CLK_MHZ + 999) / 1000);
  localparam logic [CNT_W-1:0] MRD_CYC = CNT_W'(T_MRD_CK);

  // =====================================================================
  // command encodings, decoded form
  typedef enum logic [3:0] {
    CMD_NOP = 4'h0,
    CMD_DESEL = 4'h1,
    CMD_MRS = 4'h2,
    CMD_REF = 4'h3,
    CMD_SRE = 4'h4,
    CMD_SRX = 4'h5,
    CMD_PDE = 4'h6,
    CMD_PDX = 4'h7,
    CMD_PRE = 4'h8,
    CMD_PREA = 4'h9,
    CMD_ACT = 4'ha,
    CMD_RD = 4'hb,
    CMD_WR = 4'hc,
    CMD_RSVD = 4'hd
  } dcdbs_cmd_e;

  // per-bank state
  typedef enum logic [2:0] {
    B_IDLE = 3'h0,
    B_ACTING = 3'h1,
    B_ACTIVE = 3'h2,
    B_READ = 3'h3,
    B_WRITE = 3'h4,
    B_RD_AP = 3'h5,
    B_WR_AP = 3'h6,
    B_PRECH = 3'h7
  } dcdbs_bank_e;

  // device-wide state
  typedef enum logic [2:0] {
    G_NORMAL = 3'h0,
    G_REFRESH = 3'h1,
    G_MRD = 3'h2,
    G_SELF = 3'h3,
    G_XSNR = 3'h4,
    G_PDOWN = 3'h5
  } dcdbs_glob_e;

  // =====================================================================
  // pin codes {cs_n, ras_n, cas_n, we_n}
  localparam logic [3:0] CODE_MRS = 4'h0;
  localparam logic [3:0] CODE_REF = 4'h1;
  localparam logic [3:0] CODE_PRE = 4'h2;
  localparam logic [3:0] CODE_ACT = 4'h3;
  localparam logic [3:0] CODE_WR = 4'h4;
  localparam logic [3:0] CODE_RD = 4'h5;
  localparam logic [3:0] CODE_NOP = 4'h7;
  localparam logic [3:0] CODE_DESEL = 4'hf;

  // pin code for a command; cke-only commands travel as deselect
  function automatic logic [3:0] dcdbs_code(input dcdbs_cmd_e c);
    case (c)
      CMD_MRS: dcdbs_code = CODE_MRS;
      CMD_REF, CMD_SRE: dcdbs_code = CODE_REF;
      CMD_PRE, CMD_PREA: dcdbs_code = CODE_PRE;
      CMD_ACT: dcdbs_code = CODE_ACT;
      CMD_WR: dcdbs_code = CODE_WR;
      CMD_RD: dcdbs_code = CODE_RD;
      CMD_NOP: dcdbs_code = CODE_NOP;
      default: dcdbs_code = CODE_DESEL;
    endcase
  endfunction

endpackage

// File: inc/dcdbs_if.sv
`timescale 1ns/10ps
// =====================================================================
// command pins between controller and device
interface dcdbs_if;
  logic cke;
  logic cs_n;
  logic ras_n;
  logic cas_n;
  logic we_n;
  logic [dcdbs_pkg::BA_W-1:0] ba;
  logic [dcdbs_pkg::ADDR_W-1:0] addr;
  logic odt;

  modport ctrl (output cke, cs_n, ras_n, cas_n, we_n, ba, addr, odt);
  modport dev (input cke, cs_n, ras_n, cas_n, we_n, ba, addr, odt);
endinterface

// File: src/dcdbs_ctrl.sv
`timescale 1ns/10ps
// =====================================================================
// controller end: issues only commands the device may legally take, save a PDX request out of self refresh, which starts no xsnr wait
module dcdbs_ctrl #(
  parameter int BURST_LEN = 4,
  parameter bit BIG_DENSITY = 1'b1
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic srst_i,
  // user request
  input wire logic req_valid_i,
  input wire dcdbs_pkg::dcdbs_cmd_e req_cmd_i,
  input wire logic [dcdbs_pkg::BA_W-1:0] req_ba_i,
  input wire logic [dcdbs_pkg::ADDR_W-1:0] req_addr_i,
  input wire logic odt_i,
  // user answer
  output logic ack_o,
  output logic rej_o,
  // pins
  dcdbs_if.ctrl pins
);

  localparam int NB = dcdbs_pkg::NBANK;
  localparam int CW = dcdbs_pkg::CNT_W;
  localparam logic [CW-1:0] BURST_CYC = CW'(BURST_LEN / 2);

  if (BURST_LEN != 4 && BURST_LEN != 8) begin : g_chk
    $error("BURST_LEN must be 4 or 8");
  end

  // =====================================================================
  // shadow of bank and device timing
  logic [NB-1:0] open_r;
  logic [CW-1:0] bcnt_r [NB];
  logic [CW-1:0] gcnt_r;
  logic low_r;
  logic [dcdbs_pkg::BA_W-1:0] bsel;
  logic all_free;
  logic all_closed;
  logic ok;

  // two bank bits only below the larger densities
  assign bsel = BIG_DENSITY ? req_ba_i : {1'b0, req_ba_i[1:0]}; // see R11

  // legality of the request against the shadow state
  always_comb begin
    all_free = (gcnt_r == '0);
    all_closed = ~|open_r;
    for (int i = 0; i < NB; i++) begin
      if (bcnt_r[i] != '0) begin
        all_free = 1'b0;
      end
    end
    ok = 1'b0;
    case (req_cmd_i)
      dcdbs_pkg::CMD_NOP: ok = 1'b1;
      dcdbs_pkg::CMD_ACT: ok = !low_r && gcnt_r == '0 && bcnt_r[bsel] == '0 && !open_r[bsel]; // see R19
      // bursts are never cut short, also covering BL4
      dcdbs_pkg::CMD_RD, dcdbs_pkg::CMD_WR, dcdbs_pkg::CMD_PRE: begin
        ok = !low_r && gcnt_r == '0 && bcnt_r[bsel] == '0 && open_r[bsel]; // see R12
      end
      dcdbs_pkg::CMD_PREA: ok = !low_r && all_free;
      dcdbs_pkg::CMD_MRS, dcdbs_pkg::CMD_REF, dcdbs_pkg::CMD_SRE: ok = !low_r && all_free && all_closed; // see R22
      dcdbs_pkg::CMD_PDE: ok = !low_r && gcnt_r == '0; // see R9
      dcdbs_pkg::CMD_SRX, dcdbs_pkg::CMD_PDX: ok = low_r;
      default: ok = 1'b0;
    endcase
  end

  // pin drive; refused or absent requests show deselect
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n} <= dcdbs_pkg::CODE_DESEL;
      pins.cke <= 1'b1;
      pins.ba <= '0;
      pins.addr <= '0;
      pins.odt <= 1'b0;
      low_r <= 1'b0;
    end else begin
      pins.odt <= odt_i;
      pins.ba <= req_ba_i;
      pins.addr <= req_addr_i;
      if (req_valid_i && ok) begin
        {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n} <= dcdbs_pkg::dcdbs_code(req_cmd_i); // see R1
        if (req_cmd_i == dcdbs_pkg::CMD_SRE || req_cmd_i == dcdbs_pkg::CMD_PDE) begin
          pins.cke <= 1'b0; // see R8
          low_r <= 1'b1;
        end else if (req_cmd_i == dcdbs_pkg::CMD_SRX || req_cmd_i == dcdbs_pkg::CMD_PDX) begin
          pins.cke <= 1'b1;
          low_r <= 1'b0;
        end
      end else begin
        {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n} <= dcdbs_pkg::CODE_DESEL;
      end
    end
  end

  // answer pulses
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      ack_o <= 1'b0;
      rej_o <= 1'b0;
    end else begin
      ack_o <= req_valid_i && ok;
      rej_o <= req_valid_i && !ok;
    end
  end

  // device-wide waits: only nop or deselect until they run out
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      gcnt_r <= '0;
    end else if (req_valid_i && ok && req_cmd_i == dcdbs_pkg::CMD_REF) begin
      gcnt_r <= dcdbs_pkg::RFC_CYC - 1'b1; // see R21
    end else if (req_valid_i && ok && req_cmd_i == dcdbs_pkg::CMD_MRS) begin
      gcnt_r <= dcdbs_pkg::MRD_CYC - 1'b1;
    end else if (req_valid_i && ok && req_cmd_i == dcdbs_pkg::CMD_SRX) begin
      gcnt_r <= dcdbs_pkg::XSNR_CYC - 1'b1; // see R13
    end else if (gcnt_r != '0) begin
      gcnt_r <= gcnt_r - 1'b1;
    end
  end

  // per-bank shadow: open row and cycles until the next command
  for (genvar b = 0; b < NB; b++) begin : g_bank
    logic hit;
    assign hit = req_valid_i && ok && bsel == dcdbs_pkg::BA_W'(b);
    always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
        open_r[b] <= 1'b0;
        bcnt_r[b] <= '0;
      end else if (req_valid_i && ok && req_cmd_i == dcdbs_pkg::CMD_PREA && open_r[b]) begin
        open_r[b] <= 1'b0;
        bcnt_r[b] <= dcdbs_pkg::RP_CYC - 1'b1;
      end else if (hit && req_cmd_i == dcdbs_pkg::CMD_ACT) begin
        open_r[b] <= 1'b1;
        bcnt_r[b] <= dcdbs_pkg::RCD_CYC - 1'b1; // see R19
      end else if (hit && req_cmd_i == dcdbs_pkg::CMD_PRE) begin
        open_r[b] <= 1'b0;
        bcnt_r[b] <= dcdbs_pkg::RP_CYC - 1'b1;
      end else if (hit && (req_cmd_i == dcdbs_pkg::CMD_RD || req_cmd_i == dcdbs_pkg::CMD_WR)) begin
        open_r[b] <= !req_addr_i[dcdbs_pkg::A10_BIT];
        bcnt_r[b] <= req_addr_i[dcdbs_pkg::A10_BIT] ? BURST_CYC + dcdbs_pkg::RP_CYC - 1'b1 : BURST_CYC - 1'b1;
      end else if (bcnt_r[b] != '0) begin
        bcnt_r[b] <= bcnt_r[b] - 1'b1;
      end
    end
  end

endmodule

// File: src/dcdbs_device.sv
// Functional notes
// R1 - commands decoded only at rising clock edge
// R2 - all-low code with cke high: mode load
// R3 - activate row, only into idle bank
// R4 - read burst, a10 asks auto precharge
// R5 - write burst, a10 asks auto precharge
// R6 - precharge one bank, or all with a10
// R7 - deselect and nop continue running operation
// R8 - refresh with cke falling enters self refresh
// R9 - cke edges with nop enter/exit power-down
// R10 - odt never alters decoding; off in self refresh
// R11 - third bank bit only for large densities
// R12 - controller never cuts short bl4 bursts
// R13 - legality needs cke high twice, xsnr met
// R14 - legality follows the target bank's state
// R15 - idle bank accepts activate; refresh needs idle
// R16 - row-active bank takes read, write, precharge
// R17 - reading bank takes read, write, precharge
// R18 - writing bank takes read, write, precharge
// R19 - transient bank gets only nop from controller
// R20 - activate and precharge transients end timed
// R21 - after refresh only nop until trfc
// R22 - refresh/mode load only with banks idle
`timescale 1ns/10ps
// =====================================================================
// device end: command decode and per-bank legality
module dcdbs_device #(
  parameter int BURST_LEN = 4,
  parameter bit BIG_DENSITY = 1'b1
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic srst_i,
  // command pins
  dcdbs_if.dev pins,
  // decoded command report
  output dcdbs_pkg::dcdbs_cmd_e cmd_o,
  output logic cmd_valid_o,
  output logic illegal_o,
  output logic [dcdbs_pkg::BA_W-1:0] cmd_bank_o,
  output logic [dcdbs_pkg::ADDR_W-1:0] cmd_addr_o,
  output logic auto_pre_o,
  // device state
  output logic [dcdbs_pkg::NBANK*dcdbs_pkg::BST_W-1:0] bank_state_o,
  output logic self_refresh_o,
  output logic power_down_o,
  output logic odt_en_o
);

  localparam int NB = dcdbs_pkg::NBANK;
  localparam int CW = dcdbs_pkg::CNT_W;
  localparam logic [CW-1:0] BURST_CYC = CW'(BURST_LEN / 2);

  if (BURST_LEN != 4 && BURST_LEN != 8) begin : g_chk
    $error("BURST_LEN must be 4 or 8");
  end

  // =====================================================================
  // decode
  dcdbs_pkg::dcdbs_glob_e glob_r;
  dcdbs_pkg::dcdbs_bank_e bank_st [NB];
  dcdbs_pkg::dcdbs_cmd_e base;
  dcdbs_pkg::dcdbs_cmd_e cmd;
  logic [CW-1:0] gcnt_r;
  logic cke_prev_r;
  logic [dcdbs_pkg::BA_W-1:0] bsel;
  logic a10;
  logic nopish;
  logic all_idle;
  logic pre_ok_all;
  logic tgt_open;
  logic legal;
  logic exec;

  assign a10 = pins.addr[dcdbs_pkg::A10_BIT];
  // small parts ignore the top bank bit
  assign bsel = BIG_DENSITY ? pins.ba : {1'b0, pins.ba[1:0]}; // see R11

  // pin code to command; odt takes no part here
  always_comb begin
    base = dcdbs_pkg::CMD_RSVD;
    if (pins.cs_n) begin
      base = dcdbs_pkg::CMD_DESEL; // see R7
    end else begin
      case ({pins.ras_n, pins.cas_n, pins.we_n}) // see R1 see R10
        3'h0: base = dcdbs_pkg::CMD_MRS; // see R2
        3'h1: base = dcdbs_pkg::CMD_REF;
        3'h2: base = a10 ? dcdbs_pkg::CMD_PREA : dcdbs_pkg::CMD_PRE; // see R6
        3'h3: base = dcdbs_pkg::CMD_ACT; // see R3
        3'h4: base = dcdbs_pkg::CMD_WR; // see R5
        3'h5: base = dcdbs_pkg::CMD_RD; // see R4
        3'h7: base = dcdbs_pkg::CMD_NOP;
        default: base = dcdbs_pkg::CMD_RSVD;
      endcase
    end
  end

  assign nopish = (base == dcdbs_pkg::CMD_NOP) || (base == dcdbs_pkg::CMD_DESEL);

  // bank summaries for device-wide commands
  always_comb begin
    all_idle = 1'b1;
    pre_ok_all = 1'b1;
    for (int i = 0; i < NB; i++) begin
      if (bank_st[i] != dcdbs_pkg::B_IDLE) begin
        all_idle = 1'b0;
      end
      // every bank closed by precharge-all must be precharge-ready
      if (!(bank_st[i] inside {dcdbs_pkg::B_IDLE, dcdbs_pkg::B_ACTIVE, dcdbs_pkg::B_READ, dcdbs_pkg::B_WRITE})) begin
        pre_ok_all = 1'b0;
      end
    end
  end

  // target bank holds an open row and is not in a transient
  assign tgt_open = bank_st[bsel] inside {dcdbs_pkg::B_ACTIVE, dcdbs_pkg::B_READ, dcdbs_pkg::B_WRITE}; // see R14

  // command from pins and cke history, with its legality
  always_comb begin
    cmd = dcdbs_pkg::CMD_NOP;
    legal = 1'b1;
    if (cke_prev_r && pins.cke) begin
      cmd = base;
      case (base)
        dcdbs_pkg::CMD_NOP, dcdbs_pkg::CMD_DESEL: legal = 1'b1;
        dcdbs_pkg::CMD_MRS, dcdbs_pkg::CMD_REF: legal = all_idle; // see R15
        dcdbs_pkg::CMD_ACT: legal = bank_st[bsel] == dcdbs_pkg::B_IDLE; // see R15
        // row-active, read and write states share the same set
        dcdbs_pkg::CMD_RD, dcdbs_pkg::CMD_WR, dcdbs_pkg::CMD_PRE: legal = tgt_open; // see R16 see R17 see R18
        dcdbs_pkg::CMD_PREA: legal = pre_ok_all;
        default: legal = 1'b0;
      endcase
      // during refresh, mode wait and exit recovery only nop or deselect passes
      if (glob_r != dcdbs_pkg::G_NORMAL && !nopish) begin
        legal = 1'b0; // see R13
      end
    end else if (cke_prev_r && !pins.cke) begin
      if (base == dcdbs_pkg::CMD_REF) begin
        cmd = dcdbs_pkg::CMD_SRE; // see R8
        legal = glob_r == dcdbs_pkg::G_NORMAL && all_idle;
      end else if (nopish) begin
        cmd = dcdbs_pkg::CMD_PDE; // see R9
        legal = glob_r == dcdbs_pkg::G_NORMAL;
      end else begin
        cmd = base;
        legal = 1'b0;
      end
    end else if (!cke_prev_r && pins.cke) begin
      cmd = (glob_r == dcdbs_pkg::G_SELF) ? dcdbs_pkg::CMD_SRX : dcdbs_pkg::CMD_PDX;
      legal = nopish;
    end
  end

  // illegal commands leave all state alone, save the cke-rise exit from self refresh or power-down
  assign exec = legal && (cmd != dcdbs_pkg::CMD_NOP) && (cmd != dcdbs_pkg::CMD_DESEL);

  // =====================================================================
  // device-wide state
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      cke_prev_r <= 1'b1;
    end else begin
      cke_prev_r <= pins.cke; // see R13
    end
  end

  // timed states leave when the count reaches one, giving n full cycles
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      glob_r <= dcdbs_pkg::G_NORMAL;
      gcnt_r <= '0;
      self_refresh_o <= 1'b0;
      power_down_o <= 1'b0;
    end else begin
      case (glob_r)
        dcdbs_pkg::G_NORMAL: begin
          if (exec && cmd == dcdbs_pkg::CMD_REF) begin
            glob_r <= dcdbs_pkg::G_REFRESH;
            gcnt_r <= dcdbs_pkg::RFC_CYC - 1'b1;
          end else if (exec && cmd == dcdbs_pkg::CMD_MRS) begin
            glob_r <= dcdbs_pkg::G_MRD;
            gcnt_r <= dcdbs_pkg::MRD_CYC - 1'b1;
          end else if (exec && cmd == dcdbs_pkg::CMD_SRE) begin
            glob_r <= dcdbs_pkg::G_SELF;
            self_refresh_o <= 1'b1;
          end else if (exec && cmd == dcdbs_pkg::CMD_PDE) begin
            glob_r <= dcdbs_pkg::G_PDOWN;
            power_down_o <= 1'b1;
          end
        end
        dcdbs_pkg::G_REFRESH, dcdbs_pkg::G_MRD, dcdbs_pkg::G_XSNR: begin
          if (gcnt_r <= 1) begin
            glob_r <= dcdbs_pkg::G_NORMAL;
            gcnt_r <= '0;
          end else begin
            gcnt_r <= gcnt_r - 1'b1;
          end
        end
        // exit is taken on cke alone, whatever the encoding
        dcdbs_pkg::G_SELF: begin
          if (cmd == dcdbs_pkg::CMD_SRX) begin
            glob_r <= dcdbs_pkg::G_XSNR; // see R8 see R13
            gcnt_r <= dcdbs_pkg::XSNR_CYC - 1'b1;
            self_refresh_o <= 1'b0;
          end
        end
        dcdbs_pkg::G_PDOWN: begin
          if (cmd == dcdbs_pkg::CMD_PDX) begin
            glob_r <= dcdbs_pkg::G_NORMAL; // see R9
            power_down_o <= 1'b0;
          end
        end
        default: glob_r <= dcdbs_pkg::G_NORMAL;
      endcase
    end
  end

  // =====================================================================
  // per-bank state machines
  for (genvar b = 0; b < NB; b++) begin : g_bank
    dcdbs_pkg::dcdbs_bank_e st_r;
    logic [CW-1:0] cnt_r;
    logic hit;
    assign hit = exec && bsel == dcdbs_pkg::BA_W'(b);
    assign bank_st[b] = st_r;
    assign bank_state_o[b*dcdbs_pkg::BST_W +: dcdbs_pkg::BST_W] = st_r;

    always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
        st_r <= dcdbs_pkg::B_IDLE;
        cnt_r <= '0;
      end else if ((exec && cmd == dcdbs_pkg::CMD_PREA && st_r != dcdbs_pkg::B_IDLE) ||
                   (hit && cmd == dcdbs_pkg::CMD_PRE)) begin
        st_r <= dcdbs_pkg::B_PRECH; // see R6 see R20
        cnt_r <= dcdbs_pkg::RP_CYC - 1'b1;
      end else if (hit && cmd == dcdbs_pkg::CMD_ACT) begin
        st_r <= dcdbs_pkg::B_ACTING; // see R20
        cnt_r <= dcdbs_pkg::RCD_CYC - 1'b1;
      end else if (hit && cmd == dcdbs_pkg::CMD_RD) begin
        st_r <= a10 ? dcdbs_pkg::B_RD_AP : dcdbs_pkg::B_READ; // see R4
        cnt_r <= BURST_CYC - 1'b1;
      end else if (hit && cmd == dcdbs_pkg::CMD_WR) begin
        st_r <= a10 ? dcdbs_pkg::B_WR_AP : dcdbs_pkg::B_WRITE; // see R5
        cnt_r <= BURST_CYC - 1'b1;
      end else begin
        // nop, deselect and other banks' commands let timers run on
        case (st_r) // see R7
          dcdbs_pkg::B_ACTING, dcdbs_pkg::B_READ, dcdbs_pkg::B_WRITE: begin
            if (cnt_r <= 1) begin
              st_r <= dcdbs_pkg::B_ACTIVE; // see R16
            end else begin
              cnt_r <= cnt_r - 1'b1;
            end
          end
          dcdbs_pkg::B_RD_AP, dcdbs_pkg::B_WR_AP: begin
            if (cnt_r <= 1) begin
              st_r <= dcdbs_pkg::B_PRECH;
              cnt_r <= dcdbs_pkg::RP_CYC - 1'b1;
            end else begin
              cnt_r <= cnt_r - 1'b1;
            end
          end
          dcdbs_pkg::B_PRECH: begin
            if (cnt_r <= 1) begin
              st_r <= dcdbs_pkg::B_IDLE; // see R15
            end else begin
              cnt_r <= cnt_r - 1'b1;
            end
          end
          default: cnt_r <= '0;
        endcase
      end
    end
  end

  // =====================================================================
  // registered report of each edge's command
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      cmd_o <= dcdbs_pkg::CMD_NOP;
      cmd_valid_o <= 1'b0;
      illegal_o <= 1'b0;
      cmd_bank_o <= '0;
      cmd_addr_o <= '0;
      auto_pre_o <= 1'b0;
      odt_en_o <= 1'b0;
    end else begin
      cmd_o <= cmd;
      cmd_valid_o <= exec;
      illegal_o <= !legal;
      cmd_bank_o <= bsel;
      cmd_addr_o <= pins.addr;
      auto_pre_o <= a10;
      odt_en_o <= pins.odt && glob_r != dcdbs_pkg::G_SELF; // see R10
    end
  end

endmodule

// File: testbench/dcdbs_chk.sv
`timescale 1ns/10ps
// =====================================================================
// pin checks on the controller end
module dcdbs_chk (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic srst_i,
  // command pins
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [dcdbs_pkg::BA_W-1:0] ba,
  input wire logic [dcdbs_pkg::ADDR_W-1:0] addr,
  input wire logic odt
);
  logic [3:0] code;
  logic quiet;
  logic cke_r;
  logic self_r;
  logic [dcdbs_pkg::NBANK-1:0] open_r;
  logic [dcdbs_pkg::CNT_W-1:0] quiet_r;

  // code on the pins; deselect ignores the other three lines
  assign code = {cs_n, ras_n, cas_n, we_n};
  assign quiet = cs_n || (code == dcdbs_pkg::CODE_NOP);

  // cke history and self-refresh flag, to tell entry from exit
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      cke_r <= 1'b1;
      self_r <= 1'b0;
    end else begin
      cke_r <= cke;
      if (cke_r && !cke && code == dcdbs_pkg::CODE_REF)
        self_r <= 1'b1;
      else if (cke)
        self_r <= 1'b0;
    end
  end

  // open rows as seen on the pins; auto precharge closes at once
  always_ff @(posedge clk_sys_i) begin
    if (srst_i)
      open_r <= '0;
    else if (cke && cke_r && code == dcdbs_pkg::CODE_ACT)
      open_r[ba] <= 1'b1;
    else if (cke && cke_r && code == dcdbs_pkg::CODE_PRE && addr[dcdbs_pkg::A10_BIT])
      open_r <= '0;
    else if (cke && cke_r && (code == dcdbs_pkg::CODE_PRE || (addr[dcdbs_pkg::A10_BIT] && code[3:1] == 3'h2)))
      open_r[ba] <= 1'b0;
  end

  // cycles left in which only nop or deselect may go out
  always_ff @(posedge clk_sys_i) begin
    if (srst_i)
      quiet_r <= '0;
    else if (quiet_r != '0)
      quiet_r <= quiet_r - 1'b1;
    else if (cke && cke_r && code == dcdbs_pkg::CODE_REF)
      quiet_r <= dcdbs_pkg::RFC_CYC - 1'b1;
    else if (cke && cke_r && code == dcdbs_pkg::CODE_MRS)
      quiet_r <= dcdbs_pkg::MRD_CYC - 1'b1;
    else if (cke && !cke_r && self_r)
      quiet_r <= dcdbs_pkg::XSNR_CYC - 1'b1;
  end

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (srst_i);

  a_gap_only_nop: assert property ((quiet_r != '0) |-> quiet)
    else $error("command inside a timed gap");
  a_act_rcd_wait: assert property ((code == dcdbs_pkg::CODE_ACT) |=> (quiet || ba != $past(ba)))
    else $error("bank hit before activate delay");
  a_burst_uncut: assert property ((!quiet && ba == $past(ba)) |-> ($past(code[3:1]) != 3'h2))
    else $error("burst cut short");
  a_act_closed: assert property ((cke && cke_r && code == dcdbs_pkg::CODE_ACT) |-> !open_r[ba])
    else $error("activate to an open bank");
  a_col_open: assert property ((cke && cke_r && (code[3:1] == 3'h2 || (code == dcdbs_pkg::CODE_PRE
    && !addr[dcdbs_pkg::A10_BIT]))) |-> open_r[ba])
    else $error("access to a closed bank");
  a_refmrs_idle: assert property ((code == dcdbs_pkg::CODE_REF || code == dcdbs_pkg::CODE_MRS) |->
    (open_r == '0))
    else $error("refresh or mode load, row open");
  a_cke_fall_code: assert property ($fell(cke) |-> (quiet || code == dcdbs_pkg::CODE_REF))
    else $error("bad command at cke fall");
  a_cke_low_desel: assert property ((!cke && !cke_r) |-> cs_n)
    else $error("selected with cke low");
  a_cke_rise_nop: assert property ($rose(cke) |-> quiet)
    else $error("cke rose without nop");
endmodule

// File: testbench/tb.sv
`timescale 1ns/10ps
// =====================================================================
// bench: controller facing device, plus a device fed raw pins
module tb;
  typedef struct packed {
    logic [3:0] c;
    logic [3:0] ba;
    logic [3:0] a10;
    logic [3:0] ack;
    logic [3:0] st;
    logic [3:0] sp;
    logic [7:0] gap;
  } dcdbs_row_s;
  logic clk_sys_i = 1'b0;
  logic srst_i = 1'b1;
  logic req_valid = 1'b0;
  dcdbs_pkg::dcdbs_cmd_e req_cmd = dcdbs_pkg::CMD_NOP;
  logic [2:0] req_ba = 3'h0;
  logic [13:0] req_addr = 14'h0;
  logic ack, rej, cval, ill, ap, self_rf, pdown, r_ill, r_odt;
  dcdbs_pkg::dcdbs_cmd_e cmd, r_cmd;
  logic [2:0] cbank, r_bank;
  logic [23:0] bst, r_bst;
  int fail_count = 0;
  int tests_run = 0;
  dcdbs_if pins_if();
  dcdbs_if rogue_if();

  dcdbs_ctrl dcdbs_ctrl_i (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .req_valid_i(req_valid), .req_cmd_i(req_cmd),
    .req_ba_i(req_ba), .req_addr_i(req_addr), .odt_i(1'b1), .ack_o(ack), .rej_o(rej), .pins(pins_if.ctrl));
  dcdbs_device dcdbs_device_i (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .pins(pins_if.dev), .cmd_o(cmd),
    .cmd_valid_o(cval), .illegal_o(ill), .cmd_bank_o(cbank), .cmd_addr_o(), .auto_pre_o(ap), .bank_state_o(bst),
    .self_refresh_o(self_rf), .power_down_o(pdown), .odt_en_o());
  // small density: third bank bit must drop out
  dcdbs_device #(.BIG_DENSITY(1'b0)) dcdbs_device_2_i (.clk_sys_i(clk_sys_i), .srst_i(srst_i),
    .pins(rogue_if.dev), .cmd_o(r_cmd), .cmd_valid_o(), .illegal_o(r_ill), .cmd_bank_o(r_bank), .cmd_addr_o(),
    .auto_pre_o(), .bank_state_o(r_bst), .self_refresh_o(), .power_down_o(), .odt_en_o(r_odt));
  dcdbs_chk dcdbs_chk_i (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .cke(pins_if.cke), .cs_n(pins_if.cs_n),
    .ras_n(pins_if.ras_n), .cas_n(pins_if.cas_n), .we_n(pins_if.we_n), .ba(pins_if.ba), .addr(pins_if.addr),
    .odt(pins_if.odt));

  // row nibbles: cmd bank a10 ack state cke-state, then gap to the next legal edge
  dcdbs_row_s rows[21] = '{
    32'h20010000,
    32'h30010000,
    32'ha1000010,
    32'ha1011000,
    32'hb1013000,
    32'ha1000000,
    32'hc1116000,
    32'hb1000000,
    32'ha1011000,
    32'hc1014000,
    32'h81017000,
    32'h82000000,
    32'ha2011000,
    32'h92117000,
    32'h40010200,
    32'h50010000,
    32'ha0000012,
    32'ha0011000,
    32'h60012100,
    32'h70012000,
    32'hb0115000
  };

  // 100 MHz system clock
  initial begin
    forever #5 clk_sys_i = ~clk_sys_i;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // one request: answer after one edge, device report after two
  task automatic run(input dcdbs_row_s r);
    @(negedge clk_sys_i);
    req_valid = 1'b1;
    req_cmd = dcdbs_pkg::dcdbs_cmd_e'(r.c);
    req_ba = r.ba[2:0];
    req_addr = {3'h0, r.a10[0], 10'h2c};
    @(negedge clk_sys_i);
    req_valid = 1'b0;
    chk(ack, r.ack, "ack");
    chk(rej, !r.ack, "rej");
    @(negedge clk_sys_i);
    chk(cval, r.ack, "valid");
    chk(ill, 1'b0, "illegal");
    chk({self_rf, pdown}, r.sp, "cke state");
    if (r.ack) begin
      chk(cmd, r.c, "cmd");
      chk(cbank, r.ba, "bank");
      chk(ap, r.a10, "auto pre");
      chk(bst[r.ba*3 +: 3], r.st, "bank state");
    end
    repeat (r.gap) @(negedge clk_sys_i);
    $display("test %0h done", r.c);
  endtask

  // raw pins for one cycle, then deselect with the other lines flipped
  task automatic raw(input logic [3:0] code, input logic [2:0] ba, input logic a10, input logic ill_exp);
    @(negedge clk_sys_i);
    {rogue_if.cs_n, rogue_if.ras_n, rogue_if.cas_n, rogue_if.we_n} = code;
    rogue_if.ba = ba;
    rogue_if.addr = {3'h0, a10, 10'h15};
    @(negedge clk_sys_i);
    {rogue_if.cs_n, rogue_if.ras_n, rogue_if.cas_n, rogue_if.we_n} = {1'b1, ~code[2:0]};
    chk(r_ill, ill_exp, "raw illegal");
  endtask

  // watchdog: 4000 cycles, far past the run
  initial begin
    #40000;
    fail_count++;
    end_of_test();
  end

  initial begin
    {rogue_if.cke, rogue_if.odt} = 2'h3;
    {rogue_if.cs_n, rogue_if.ras_n, rogue_if.cas_n, rogue_if.we_n} = 4'hf;
    rogue_if.ba = 3'h0;
    rogue_if.addr = 14'h0;
    repeat (4) @(negedge clk_sys_i);
    srst_i = 1'b0;
    foreach (rows[i]) begin
      run(rows[i]);
    end
    // reset in mid-run closes every bank at once
    @(negedge clk_sys_i);
    srst_i = 1'b1;
    @(negedge clk_sys_i);
    srst_i = 1'b0;
    chk(bst, 24'h0, "reset banks");
    chk(cmd, dcdbs_pkg::CMD_NOP, "reset cmd");
    run(32'ha0011000);
    // back to back activates to two banks
    req_valid = 1'b1;
    req_cmd = dcdbs_pkg::CMD_ACT;
    req_ba = 3'h3;
    @(negedge clk_sys_i);
    req_ba = 3'h4;
    chk(ack, 1'b1, "first act");
    @(negedge clk_sys_i);
    req_valid = 1'b0;
    chk(ack, 1'b1, "second act");
    chk(bst[11:9], 3'h1, "bank3");
    $display("test back to back done");
    // raw pins: broken commands are flagged and change nothing
    raw(4'h5, 3'h0, 1'b0, 1'b1);
    chk(r_bst, 24'h0, "idle kept");
    raw(4'h6, 3'h0, 1'b0, 1'b1);
    raw(4'h3, 3'h5, 1'b0, 1'b0);
    chk(r_bank, 3'h1, "bank bits");
    chk(r_bst[5:3], 3'h1, "activating");
    chk(r_odt, 1'b1, "odt");
    @(negedge clk_sys_i);
    chk(r_bst[5:3], 3'h2, "row open");
    raw(4'h3, 3'h1, 1'b0, 1'b1);
    raw(4'h0, 3'h0, 1'b0, 1'b1);
    raw(4'h2, 3'h3, 1'b1, 1'b0);
    chk(r_cmd, dcdbs_pkg::CMD_PREA, "all banks");
    $display("test raw pins done");
    end_of_test();
  end
endmodule
